// [design/dts_pkg.sv]
`default_nettype none
// ============================================================
// Shared constants for the die temperature sensor control
package dts_pkg;
	// ============================================================
	// Register map (special function register address and page)
	localparam logic [7:0] DTS_ADDR_CTL = 8'hd2;
	localparam logic [7:0] DTS_ADDR_LOW = 8'hd2;
	localparam logic [7:0] DTS_ADDR_HIGH = 8'hd3;
	localparam logic [3:0] DTS_PAGE_CTL = 4'hf;
	localparam logic [3:0] DTS_PAGE_DATA = 4'h0;
	// Control register fields
	localparam int DTS_BIT_LAUNCH = 7;
	localparam int DTS_BIT_DONE = 6;
	localparam int DTS_LEN_MSB = 2;
	localparam logic [7:0] DTS_RESET_BYTE = 8'h00;
	// ============================================================
	// Timing: clock rate, sensor clock span per step, settle tail
	localparam int DTS_CLK_MHZ = 200;
	localparam int DTS_STEP_TICKS = 256;
	localparam int DTS_SETTLE_US = 32;
	localparam int DTS_SETTLE_CYC = DTS_SETTLE_US * DTS_CLK_MHZ;
	// Sequencer states, Gray along idle, convert, settle
	typedef enum logic [1:0] {
		DTS_IDLE = 2'b00,
		DTS_CONV = 2'b01,
		DTS_SETTLE = 2'b11
	} dts_state_t;
endpackage
`default_nettype wire

// [design/dts_top.sv]
`default_nettype none
// Behaviour
// - Launch after start bit written one then zero, when idle
// - Duration: 256 sensor ticks times (2^(len+1)+1), plus 32us
// - Length field bits 2:0, read/write, resets zero
// - Completion sets done flag, control bit 6
// - Done flag cleared only by software write
// - Interrupt request when done sets from clear, if enabled
// - Result registers loaded as done flag sets
// - Result is 16-bit two's complement, 1/128 degree
// - High byte holds bits 15:8, low 7:0
// - Control page F 0xd2, data page 0 0xd2/0xd3
module dts_top import dts_pkg::*; #(
	parameter int SENSOR_DIV = 8, // System clocks per sensor clock
	parameter int SETTLE_CYCLES = DTS_SETTLE_CYC // 32 us tail in system clocks
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [3:0] sfr_page,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Sensing element result and interrupt enable
	input wire logic [15:0] sensor_value,
	input wire logic sensor_irq_enable,
	// Status outputs
	output logic irq_req,
	output logic busy
);
	// ============================================================
	// Decode helpers
	function automatic logic hit(input logic [7:0] a, input logic [3:0] p,
		input logic [7:0] ea, input logic [3:0] ep);
		hit = (a == ea) && (p == ep);
	endfunction
	// Sensor ticks in the convert phase for a length code
	function automatic logic [31:0] conv_ticks(input logic [2:0] len);
		conv_ticks = 32'(DTS_STEP_TICKS) * ((32'h1 << (32'(len) + 32'h1)) + 32'h1);
	endfunction

	// ============================================================
	// State
	dts_state_t state, next_state; // Sequencer
	logic launch, next_launch; // Start bit as written
	logic done, next_done; // Sticky completion flag
	logic [2:0] len, next_len; // Length selector
	logic [2:0] run_len, next_run_len; // Length frozen at launch
	logic [7:0] res_high, next_res_high; // Result bits 15:8
	logic [7:0] res_low, next_res_low; // Result bits 7:0
	logic [31:0] cnt, next_cnt; // Ticks or cycles remaining
	logic [31:0] div, next_div; // Sensor clock divider
	logic [7:0] next_rdata;
	logic next_irq, next_busy;
	// Access, sensor tick and finish strobes
	logic wr_ctl, wr_low, wr_high, launch_ev, tick, finish;

	// ============================================================
	// Register decode; low data register shares 0xd2 with control, high is 0xd3
	always_comb begin
		wr_ctl = sfr_wr && hit(sfr_addr, sfr_page, DTS_ADDR_CTL, DTS_PAGE_CTL);
		wr_low = sfr_wr && hit(sfr_addr, sfr_page, DTS_ADDR_LOW, DTS_PAGE_DATA);
		wr_high = sfr_wr && hit(sfr_addr, sfr_page, DTS_ADDR_HIGH, DTS_PAGE_DATA);
		// Falling write of the start bit after it was set
		launch_ev = wr_ctl && launch && !sfr_wdata[DTS_BIT_LAUNCH];
		tick = (div == 32'(SENSOR_DIV - 1));
		finish = (state == DTS_SETTLE) && (cnt == 32'h1);
	end

	// ============================================================
	// Next-state logic for sequencer, registers and read port
	always_comb begin
		next_state = state;
		next_launch = launch;
		next_done = done;
		next_len = len;
		next_run_len = run_len;
		next_res_high = res_high;
		next_res_low = res_low;
		next_cnt = cnt;
		next_div = tick ? 32'h0 : div + 32'h1;
		next_rdata = 8'h00;
		next_irq = 1'b0;
		// Software writes to control; bits 5:3 simply not stored
		if (wr_ctl) begin
			next_launch = sfr_wdata[DTS_BIT_LAUNCH];
			next_len = sfr_wdata[DTS_LEN_MSB:0];
			// Only a zero clears done; writing one is ignored
			if (!sfr_wdata[DTS_BIT_DONE]) begin
				next_done = 1'b0;
			end
		end
		// Result bytes are software writable as well
		if (wr_low) begin
			next_res_low = sfr_wdata;
		end
		if (wr_high) begin
			next_res_high = sfr_wdata;
		end
		case (state)
			DTS_IDLE: begin
				// Launch ignored while a measurement runs
				if (launch_ev) begin
					next_state = DTS_CONV;
					next_run_len = next_len;
					next_cnt = conv_ticks(next_len);
					next_div = 32'h0; // Align sensor ticks to launch
				end
			end
			DTS_CONV: begin
				if (tick) begin
					next_cnt = cnt - 32'h1;
					if (cnt == 32'h1) begin
						next_state = DTS_SETTLE;
						next_cnt = 32'(SETTLE_CYCLES);
					end
				end
			end
			DTS_SETTLE: begin
				next_cnt = cnt - 32'h1;
				if (finish) begin
					next_state = DTS_IDLE;
					// Set beats a same-cycle software clear
					next_done = 1'b1;
					// Hardware load beats software byte writes
					next_res_high = sensor_value[15:8];
					next_res_low = sensor_value[7:0];
					next_irq = sensor_irq_enable && !done;
				end
			end
			default: begin
				next_state = DTS_IDLE;
			end
		endcase
		next_busy = (next_state != DTS_IDLE);
		// Read port, one cycle latency; unmapped reads give zero
		if (sfr_rd) begin
			if (hit(sfr_addr, sfr_page, DTS_ADDR_CTL, DTS_PAGE_CTL)) begin
				next_rdata = {launch, done, 3'b000, len};
			end else if (hit(sfr_addr, sfr_page, DTS_ADDR_LOW, DTS_PAGE_DATA)) begin
				next_rdata = res_low;
			end else if (hit(sfr_addr, sfr_page, DTS_ADDR_HIGH, DTS_PAGE_DATA)) begin
				next_rdata = res_high;
			end
		end
	end

	// ============================================================
	// Registers only
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= DTS_IDLE;
			launch <= DTS_RESET_BYTE[DTS_BIT_LAUNCH];
			done <= DTS_RESET_BYTE[DTS_BIT_DONE];
			len <= DTS_RESET_BYTE[DTS_LEN_MSB:0];
			run_len <= 3'h0;
			res_high <= DTS_RESET_BYTE;
			res_low <= DTS_RESET_BYTE;
			cnt <= 32'h0;
			div <= 32'h0;
			sfr_rdata <= 8'h00;
			irq_req <= 1'b0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			launch <= next_launch;
			done <= next_done;
			len <= next_len;
			run_len <= next_run_len;
			res_high <= next_res_high;
			res_low <= next_res_low;
			cnt <= next_cnt;
			div <= next_div;
			sfr_rdata <= next_rdata;
			irq_req <= next_irq;
			busy <= next_busy;
		end
	end

	// ============================================================
	// Checks; helper counts system cycles spent in each phase
	logic [31:0] phase_cyc;
	always_ff @(posedge clk) begin
		if (!rst_b || state != next_state) begin
			phase_cyc <= 32'h0;
		end else begin
			phase_cyc <= phase_cyc + 32'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_launch_starts: assert property (state == DTS_IDLE && launch_ev |=> state == DTS_CONV)
		else $error("launch did not start a measurement");
	chk_start_needs_launch: assert property ($rose(busy) |-> $past(launch_ev))
		else $error("measurement started without launch sequence");
	chk_conv_duration: assert property (state == DTS_CONV && next_state == DTS_SETTLE
		|-> phase_cyc + 32'h1 == conv_ticks(run_len) * 32'(SENSOR_DIV))
		else $error("convert phase length wrong");
	chk_settle_duration: assert property (finish |-> phase_cyc + 32'h1 == 32'(SETTLE_CYCLES))
		else $error("settle phase length wrong");
	chk_len_write: assert property (wr_ctl |=> len == $past(sfr_wdata[2:0]))
		else $error("length field not stored");
	chk_done_sets: assert property (finish |=> done && state == DTS_IDLE)
		else $error("done not set at completion");
	chk_done_sticky: assert property (done && !(wr_ctl && !sfr_wdata[DTS_BIT_DONE]) |=> done)
		else $error("done cleared without software");
	chk_irq_pairing: assert property (irq_req |-> $rose(done) && $past(sensor_irq_enable))
		else $error("interrupt without done edge");
	chk_result_loaded: assert property (finish |=> {res_high, res_low} == $past(sensor_value))
		else $error("result not loaded with done");
	chk_reserved_zero: assert property (sfr_rd && hit(sfr_addr, sfr_page, DTS_ADDR_CTL, DTS_PAGE_CTL)
		|=> sfr_rdata[5:3] == 3'b000 && sfr_rdata[2:0] == $past(len))
		else $error("control readback wrong");
	chk_low_page: assert property (sfr_rd && hit(sfr_addr, sfr_page, DTS_ADDR_LOW, DTS_PAGE_DATA)
		|=> sfr_rdata == $past(res_low))
		else $error("low byte readback wrong");

	// Bounded form; a whole measurement can outlast any delay range
	cov_measure: cover property (busy ##1 (!busy && done));
	cov_irq: cover property (irq_req);
	cov_clear_done: cover property (done ##1 !done);
	cov_launch_ignored: cover property (busy && launch_ev);
endmodule // dts_top
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
// ============================================================
// Bench for the die temperature sensor control
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dts_pkg::*;
	// Short counts keep the run brief
	localparam int DIV = 1;
	localparam int SET = 4;
	logic clk; // System clock
	logic rst_b; // Active low reset
	logic [7:0] sfr_addr; // Register address
	logic [3:0] sfr_page; // Register page
	logic sfr_wr; // Write strobe
	logic sfr_rd; // Read strobe
	logic [7:0] sfr_wdata; // Write data
	logic [7:0] sfr_rdata; // Read data
	logic [15:0] sensor_value; // Sensing element word
	logic sensor_irq_enable; // Interrupt enable
	logic irq_req; // Interrupt pulse
	logic busy; // Measuring
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	dts_top #(.SENSOR_DIV(DIV), .SETTLE_CYCLES(SET)) dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
		.sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.sensor_value(sensor_value), .sensor_irq_enable(sensor_irq_enable), .irq_req(irq_req), .busy(busy));
	// ============================================================
	// Clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Verdict and end of run
	task complete_run;
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard, far above the two measurements
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			complete_run();
		end
	end
	// ============================================================
	// Compare helper, four-state safe
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One-cycle write strobe, driven at falling edge
	task wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_page = p;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] exp, input string nm);
		@(negedge clk);
		sfr_addr = a;
		sfr_page = p;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk(nm, {8'h00, exp}, {8'h00, sfr_rdata});
	endtask
	// Launch, time it to completion, then read back
	task meas(input logic [2:0] len, input logic [15:0] val, input logic en, input logic again);
		int n;
		n = 0;
		sensor_value = val;
		sensor_irq_enable = en;
		wr(DTS_ADDR_CTL, DTS_PAGE_CTL, {5'h10, len});
		wr(DTS_ADDR_CTL, DTS_PAGE_CTL, {5'h00, len});
		while (!(n > 2 && busy === 1'b0) && n < 3000) begin
			@(negedge clk);
			n++;
			// Relaunch while measuring must not restart the count
			if (again && n == 8) begin
				wr(DTS_ADDR_CTL, DTS_PAGE_CTL, {5'h10, len});
				wr(DTS_ADDR_CTL, DTS_PAGE_CTL, {5'h00, len});
				n += 4;
			end
		end
		// Busy spans convert ticks plus the settle tail
		chk("cycles", 16'(256 * (2 ** (len + 1) + 1) * DIV + SET), 16'(n));
		chk("irq_req", {15'h0000, en}, {15'h0000, irq_req});
		rd(DTS_ADDR_CTL, DTS_PAGE_CTL, {5'h08, len}, "control");
		rd(DTS_ADDR_HIGH, DTS_PAGE_DATA, val[15:8], "high");
		rd(DTS_ADDR_LOW, DTS_PAGE_DATA, val[7:0], "low");
	endtask
	// ============================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		sfr_addr = 8'h00;
		sfr_page = 4'h0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		sensor_value = 16'h0000;
		sensor_irq_enable = 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		// Reset values, page decode, unmapped place
		rd(DTS_ADDR_CTL, DTS_PAGE_CTL, 8'h00, "control");
		rd(DTS_ADDR_LOW, DTS_PAGE_DATA, 8'h00, "low");
		rd(DTS_ADDR_HIGH, DTS_PAGE_DATA, 8'h00, "high");
		rd(8'hd4, DTS_PAGE_DATA, 8'h00, "unmapped");
		// Reserved bits and done flag ignore written ones
		wr(DTS_ADDR_CTL, DTS_PAGE_CTL, 8'hf8);
		rd(DTS_ADDR_CTL, DTS_PAGE_CTL, 8'h80, "control");
		// Negative result, shortest length, interrupt on
		meas(3'h0, 16'hf320, 1'b1, 1'b0);
		repeat (20) @(negedge clk);
		rd(DTS_ADDR_CTL, DTS_PAGE_CTL, 8'h40, "sticky");
		// Clear without prior set must not launch
		wr(DTS_ADDR_CTL, DTS_PAGE_CTL, 8'h01);
		repeat (3) @(negedge clk);
		chk("busy", 16'h0000, {15'h0000, busy});
		rd(DTS_ADDR_CTL, DTS_PAGE_CTL, 8'h01, "cleared");
		// High result byte is writable
		wr(DTS_ADDR_HIGH, DTS_PAGE_DATA, 8'h5a);
		rd(DTS_ADDR_HIGH, DTS_PAGE_DATA, 8'h5a, "high");
		// Longer length, interrupt off
		meas(3'h1, 16'h0ce0, 1'b0, 1'b1);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
